/* File: rtl/baud_ctl.sv */
/*
  Baud control and status block: the control/status register, receiver
  idle tracking, transmit/clock idle polarity, wake-up on a receive falling
  edge and auto-baud overflow flagging, reached over APB.
  Assumes rx_pin is asynchronous to ref_clk (the serial clock is toggled on ref_clk) and that
  the transmit and measurement engines live elsewhere and report in.
*/
//
// Behaviour
// - Receive-idle flag high unless character arriving
// - Async polarity one: transmit rests low
// - Async polarity zero: transmit rests high, default
// - Sync polarity selects serial clock idle level
// - Width select picks 16 or 8 bit counter
// - Async wake-up: fall interrupts, rise clears enable
`timescale 1ns/1ps
`default_nettype none
module baud_ctl
  import baud_ctl_pkg::*;
#(
  parameter int bit_cycles = 16
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Line side
  input  wire logic        rx_pin,
  input  wire logic        tx_data,
  input  wire logic        tx_active,
  input  wire logic        clk_active,
  output logic             tx_pin,
  output logic             serial_clock_line,
  // Engine side
  input  wire logic        measure_tick,
  output logic             wide_baud_counter,
  output logic             measure_run,
  output logic             irq
);
  import baud_ctl_pkg::*;

  // The bit counter is 16 bits wide and needs at least two cycles per bit.
  if (bit_cycles < 2 || bit_cycles > 65535) begin : g_bad_bit_cycles
    $error("bit_cycles out of range");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {rx_idle, rx_start, rx_busy} rx_phase_t;

  typedef struct packed {
    rx_phase_t              phase;
    logic [15:0]            bit_count;
    logic [3:0]             char_count;
    logic                   overflow;
    logic                   idle;
    logic                   polarity;
    logic                   wide;
    logic                   wakeup;
    logic                   measure;
    logic                   sync_mode;
    logic [irq_width-1:0]   status;
    logic [irq_width-1:0]   mask;
    logic [measure_width-1:0] timer;
    logic [31:0]            rdata;
    logic                   ready;
    logic                   err;
    logic                   tx;
    logic                   sck;
    logic                   irq;
  } ctl_state_t;

  ctl_state_t state;
  ctl_state_t next_state;

  logic rx_level;
  logic rx_rise;
  logic rx_fall;

  pin_sync #(.reset_level(1'b1)) u_rx_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (rx_pin),
    .level   (rx_level),
    .rise    (rx_rise),
    .fall    (rx_fall)
  );

  logic        access;
  logic        wr;
  logic        rd;
  logic [7:0]  ctl_read;
  logic        wrap;

  assign access = psel & penable & ~state.ready;
  assign wr     = access & pwrite;
  assign rd     = access & ~pwrite;
  assign wrap   = state.measure & measure_tick & (&state.timer);
  assign ctl_read = {state.overflow, state.idle, 1'b0, state.polarity,
                     state.wide, 1'b0, state.wakeup, state.measure};

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_state       = state;
    next_state.ready = access;
    next_state.err   = 1'b0;
    next_state.rdata = 32'h0000_0000;

    // Receiver tracking: a fall that survives the start check begins a
    // character, idle returns after a full character time.
    case (state.phase)
      rx_idle: begin
        if (rx_fall && !state.sync_mode) begin
          next_state.phase     = rx_start;
          next_state.bit_count = 16'h0000;
        end
      end
      rx_start: begin
        next_state.bit_count = state.bit_count + 16'h0001;
        if (rx_level) begin
          next_state.phase = rx_idle;
        end else if (state.bit_count >= 16'(rx_start_cycles)) begin
          next_state.phase      = rx_busy;
          next_state.bit_count  = 16'h0000;
          next_state.char_count = 4'h0;
        end
      end
      rx_busy: begin
        next_state.bit_count = state.bit_count + 16'h0001;
        if (state.bit_count >= 16'(bit_cycles - 1)) begin
          next_state.bit_count  = 16'h0000;
          next_state.char_count = state.char_count + 4'h1;
          if (state.char_count >= 4'(char_bits - 1)) begin
            next_state.phase = rx_idle;
          end
        end
      end
      default: next_state.phase = rx_idle;
    endcase
    // Auto-baud timer and overflow.
    if (state.measure && measure_tick) begin
      next_state.timer = state.timer + 16'h0001;
    end
    if (wrap && !state.sync_mode) begin
      next_state.overflow = 1'b1;
    end

    // Register access.
    if (wr) begin
      case (paddr)
        baud_control_offset: begin
          next_state.polarity = pwdata[line_polarity_bit];
          next_state.wide     = pwdata[wide_baud_counter_bit];
          next_state.wakeup   = pwdata[wakeup_enable_bit];
          next_state.measure  = pwdata[autobaud_measure_bit];
          if (pwdata[autobaud_measure_bit] && !state.measure) begin
            next_state.timer    = '0;
            next_state.overflow = 1'b0;
          end
        end
        irq_mask_offset:     next_state.mask = pwdata[irq_width-1:0];
        line_control_offset: next_state.sync_mode = pwdata[sync_mode_bit];
        irq_status_offset, measure_offset: ;
        default:             next_state.err = 1'b1;
      endcase
    end
    if (rd) begin
      case (paddr)
        baud_control_offset: next_state.rdata = {24'h000000, ctl_read};
        irq_status_offset: begin
          next_state.rdata  = {30'h0, state.status};
          next_state.status = '0;
        end
        irq_mask_offset:     next_state.rdata = {30'h0, state.mask};
        line_control_offset: next_state.rdata = {31'h0, state.sync_mode};
        measure_offset:      next_state.rdata = {16'h0000, state.timer};
        default:             next_state.err   = 1'b1;
      endcase
    end

    // Wake-up: hardware events win over the read clear.
    if (state.wakeup && !state.sync_mode) begin
      if (rx_fall) begin
        next_state.status[irq_wakeup_bit] = 1'b1;
      end
      if (rx_rise) begin
        next_state.wakeup = 1'b0;
      end
    end
    if (wrap && !state.sync_mode) begin
      next_state.status[irq_overflow_bit] = 1'b1;
    end

    // Idle line levels.
    if (tx_active) begin
      next_state.tx = tx_data;
    end else begin
      next_state.tx = ~next_state.polarity;
    end
    if (clk_active) begin
      next_state.sck = ~state.sck;
    end else begin
      next_state.sck = next_state.polarity;
    end

    // Idle uses the next mode so that a mode write cannot leave a stale flag.
    next_state.idle = (next_state.phase != rx_busy) | next_state.sync_mode;
    next_state.irq = |(next_state.status & next_state.mask);

    if (!rst_n) begin
      next_state           = '0;
      next_state.phase     = rx_idle;
      next_state.idle      = baud_control_reset[receiver_idle_bit];
      next_state.tx        = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    state <= next_state;
  end

  assign prdata            = state.rdata;
  assign pready            = state.ready;
  assign pslverr           = state.err;
  assign tx_pin            = state.tx;
  assign serial_clock_line = state.sck;
  assign wide_baud_counter = state.wide;
  assign measure_run       = state.measure;
  assign irq               = state.irq;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  idle_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state.phase == rx_busy && !state.sync_mode) |-> !state.idle)
    else $error("idle flag high while receiving");
  tx_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($past(!tx_active) && state.polarity && $past(state.polarity)) |-> !tx_pin)
    else $error("transmit not resting low");
  tx_high_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($past(!tx_active) && !state.polarity && $past(!state.polarity)) |-> tx_pin)
    else $error("transmit not resting high");
  sck_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($past(!clk_active) && $stable(state.polarity)) |-> serial_clock_line == state.polarity)
    else $error("clock idle level wrong");
  width_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wide_baud_counter == state.wide ##0 (wr && paddr == baud_control_offset)
    |=> wide_baud_counter == $past(pwdata[wide_baud_counter_bit]))
    else $error("width select not written");
  sequence wake_fall_s;
    state.wakeup && !state.sync_mode && rx_fall;
  endsequence
  wake_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wake_fall_s |=> state.status[irq_wakeup_bit])
    else $error("wake-up event lost");
  wake_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state.wakeup && !state.sync_mode && rx_rise) |=> !state.wakeup)
    else $error("wake-up enable not cleared");
  overflow_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrap && !state.sync_mode) |=> state.overflow ##1 state.overflow)
    else $error("overflow flag not held");
  irq_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq == |($past(next_state.status) & $past(next_state.mask)))
    else $error("interrupt level mismatch");

endmodule
`default_nettype wire

/* File: rtl/baud_ctl_pkg.sv */
/*
  Package for the baud control and status block: register offsets, bit
  positions, reset values and timing counts.
  Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
package baud_ctl_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] baud_control_offset = 8'h00;
  localparam logic [7:0] irq_status_offset   = 8'h04;
  localparam logic [7:0] irq_mask_offset     = 8'h08;
  localparam logic [7:0] line_control_offset = 8'h0c;
  localparam logic [7:0] measure_offset      = 8'h10;

  // ----------------------------------------------------------------------
  // Fields of baud_control
  // ----------------------------------------------------------------------
  localparam int autobaud_overflow_bit  = 7;
  localparam int receiver_idle_bit      = 6;
  localparam int line_polarity_bit      = 4;
  localparam int wide_baud_counter_bit  = 3;
  localparam int wakeup_enable_bit      = 1;
  localparam int autobaud_measure_bit   = 0;
  localparam logic [7:0] baud_control_reset = 8'h40;
  localparam logic [7:0] baud_control_wmask = 8'h1b;

  // Fields of line_control: bit 0 selects synchronous mode.
  localparam int sync_mode_bit = 0;

  // Interrupt status and mask bits.
  localparam int irq_wakeup_bit   = 0;
  localparam int irq_overflow_bit = 1;
  localparam int irq_width        = 2;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int clk_period_ns     = 10;
  localparam int measure_width     = 16;
  localparam int rx_start_ns       = 80;
  localparam int rx_start_cycles   = (rx_start_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int char_bits         = 10;

endpackage

/* File: rtl/pin_sync.sv */
/*
  Two-flop synchroniser with rise and fall detection after the second flop.
  Assumes the input is asynchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter logic reset_level = 1'b1
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Pin and derived signals
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  always_comb begin
    next_state      = state;
    next_state.meta = pin;
    next_state.sync = state.meta;
    next_state.last = state.sync;
    if (!rst_n) begin
      next_state = '{reset_level, reset_level, reset_level};
    end
  end

  always_ff @(posedge ref_clk) begin
    state <= next_state;
  end

  assign level = state.sync;
  assign rise  = state.sync & ~state.last;
  assign fall  = ~state.sync & state.last;

endmodule
`default_nettype wire

/* File: dv/remote_node.sv */
/*
  Model of the remote serial node that drives the receive line.
  Assumes an idle-high line with one start bit, eight data bits sent
  least significant first, and one stop bit.
*/
`timescale 1ns/1ps
`default_nettype none
module remote_node #(
  parameter int bit_ns = 160
) (
  // Request from the bench
  input  wire logic       send,
  input  wire logic [7:0] data,
  // Line
  output logic            rx_line
);
  // ----------------------------------------------------------------------
  // Frame generator
  // ----------------------------------------------------------------------
  // The line rests at its pulled-up level between frames.
  initial begin
    rx_line = 1'b1;
    forever begin
      @(posedge send);
      rx_line = 1'b0;
      #(bit_ns);
      for (int i = 0; i < 8; i++) begin
        rx_line = data[i];
        #(bit_ns);
      end
      rx_line = 1'b1;
      #(bit_ns);
    end
  end
endmodule
`default_nettype wire

/* File: dv/uart_baud_control_status_tb.sv */
/*
  Self-checking bench for the baud control block over APB.
  Assumes the remote node model and the default bit_cycles of 16.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_baud_control_status_tb;
  import baud_ctl_pkg::*;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        rx_pin, tx_data, tx_active, clk_active, tx_pin, serial_clock_line;
  logic        measure_tick, wide_baud_counter, measure_run, irq, send, e;
  int          err_count, tests_run;

  baud_ctl DUT (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pin(rx_pin), .tx_data(tx_data), .tx_active(tx_active),
    .clk_active(clk_active), .tx_pin(tx_pin), .serial_clock_line(serial_clock_line),
    .measure_tick(measure_tick), .wide_baud_counter(wide_baud_counter),
    .measure_run(measure_run), .irq(irq));
  remote_node node (.send(send), .data(8'h55), .rx_line(rx_pin));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge; the answer
  // is taken at that same edge and the request is released right after it.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 20) begin
        err_count++;
        results();
      end
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("read data", exp, q);
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    err_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    {psel, penable, pwrite, tx_data, tx_active, clk_active, measure_tick, send} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(baud_control_offset, 32'h40);
    chk("tx_pin", 32'h1, {31'h0, tx_pin});
    wr(baud_control_offset, 32'h10);
    settle(3);
    chk("tx_pin", 32'h0, {31'h0, tx_pin});
    rd(baud_control_offset, 32'h50);
    wr(line_control_offset, 32'h1);
    settle(3);
    chk("serial_clock_line", 32'h1, {31'h0, serial_clock_line});
    wr(baud_control_offset, 32'h0);
    settle(3);
    chk("serial_clock_line", 32'h0, {31'h0, serial_clock_line});
    wr(line_control_offset, 32'h0);
    settle(3);
    chk("tx_pin", 32'h1, {31'h0, tx_pin});
    // While a character is sent the line follows the data, not the idle level.
    @(posedge ref_clk);
    tx_active <= 1'b1;
    settle(3);
    chk("tx_pin", 32'h0, {31'h0, tx_pin});
    @(posedge ref_clk);
    tx_active <= 1'b0;
    settle(3);
    chk("tx_pin", 32'h1, {31'h0, tx_pin});
    wr(baud_control_offset, 32'h8);
    settle(3);
    chk("wide_baud_counter", 32'h1, {31'h0, wide_baud_counter});
    wr(baud_control_offset, 32'h0);
    settle(3);
    chk("wide_baud_counter", 32'h0, {31'h0, wide_baud_counter});
    // Wake-up on the start bit of a frame from the remote node.
    wr(irq_mask_offset, 32'h1);
    wr(baud_control_offset, 32'h2);
    @(posedge ref_clk);
    send <= 1'b1;
    for (int n = 0; n < 50 && irq !== 1'b1; n++) @(negedge ref_clk);
    chk("irq", 32'h1, {31'h0, irq});
    settle(25);
    rd(baud_control_offset, 32'h0);
    rd(irq_status_offset, 32'h1);
    settle(3);
    chk("irq", 32'h0, {31'h0, irq});
    @(posedge ref_clk);
    send <= 1'b0;
    settle(200);
    rd(baud_control_offset, 32'h40);
    // A full wrap of the measurement timer, first masked.
    wr(irq_mask_offset, 32'h0);
    wr(baud_control_offset, 32'h1);
    settle(3);
    chk("measure_run", 32'h1, {31'h0, measure_run});
    @(posedge ref_clk);
    measure_tick <= 1'b1;
    repeat (65540) @(posedge ref_clk);
    measure_tick <= 1'b0;
    settle(3);
    rd(baud_control_offset, 32'hc1);
    rd(measure_offset, 32'h4);
    chk("irq", 32'h0, {31'h0, irq});
    wr(irq_mask_offset, 32'h2);
    settle(3);
    chk("irq", 32'h1, {31'h0, irq});
    rd(irq_status_offset, 32'h2);
    settle(3);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b0, 8'h20, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
    results();
  end
endmodule
`default_nettype wire
